// file: shared/tlip_pkg.sv
// Constants for the two-level interrupt prioritizer: source indices, vectors, timing.
// Assumes a single core clock; included by the prioritizer module only by package reference.
`default_nettype none

package tlip_pkg;

  localparam int unsigned NUM_SRC = 10;
  localparam int unsigned VEC_W = 8;

  // Source index equals natural rank minus one
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_TMR0 = 1;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_TMR1 = 3;
  localparam int unsigned SRC_SER = 4;
  localparam int unsigned SRC_TMR2 = 5;
  localparam int unsigned SRC_EXT2 = 6;
  localparam int unsigned SRC_EXT3 = 7;
  localparam int unsigned SRC_EXT4 = 8;
  localparam int unsigned SRC_EXT5 = 9;

  // Vector addresses in rank order
  localparam logic [VEC_W-1:0] VEC_EXT0 = 8'h03;
  localparam logic [VEC_W-1:0] VEC_TMR0 = 8'h0B;
  localparam logic [VEC_W-1:0] VEC_EXT1 = 8'h13;
  localparam logic [VEC_W-1:0] VEC_TMR1 = 8'h1B;
  localparam logic [VEC_W-1:0] VEC_SER = 8'h23;
  localparam logic [VEC_W-1:0] VEC_TMR2 = 8'h2B;
  localparam logic [VEC_W-1:0] VEC_EXT2 = 8'h43;
  localparam logic [VEC_W-1:0] VEC_EXT3 = 8'h4B;
  localparam logic [VEC_W-1:0] VEC_EXT4 = 8'h53;
  localparam logic [VEC_W-1:0] VEC_EXT5 = 8'h5B;

  // Oscillator settling count after a stop-mode wake
  localparam int unsigned WAKE_CLOCKS = 65536;
  localparam int unsigned WAKE_CNT_W = 17;

  // Reset values
  localparam logic [VEC_W-1:0] VEC_RESET = 8'h00;
  localparam logic [NUM_SRC-1:0] PEND_RESET = 10'h000;

endpackage : tlip_pkg

`default_nettype wire

// file: test/tlip_checker_sva.sv
// Port checker for the two-level interrupt prioritizer.
// Assumes it is bound onto tlip_prioritizer and clk_en is held high.
`default_nettype none
module tlip_checker #(
  parameter int unsigned WAKE_CLOCKS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests and controls
  input wire logic ext_req_zero,
  input wire logic ext_req_two,
  input wire logic [9:0] src_enable,
  input wire logic [9:0] src_high_level,
  input wire logic stop_mode_enter,
  input wire logic vector_ack,
  // Outputs under watch
  input wire logic irq_valid,
  input wire logic [7:0] irq_vector,
  input wire logic [9:0] edge_pending,
  input wire logic in_service_high,
  input wire logic core_halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic woke;
  int unsigned cnt;
  ////////////////////////////////////////
  // Settle counter, only started by a wake edge so a plain stop is not timed
  always_ff @(posedge clk) begin
    if (rst || !core_halted) begin
      woke <= 1'b0;
      cnt <= 0;
    end else if (woke) begin
      cnt <= cnt + 1;
    end else begin
      woke <= $rose(ext_req_two) && src_enable[6];
    end
  end
  // An accepted vector
  sequence s_accept;
    irq_valid && vector_ack && !core_halted;
  endsequence
  a_vec_legal: assert property (irq_valid |-> irq_vector inside
    {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h43, 8'h4B, 8'h53, 8'h5B})
    else $error("vector outside the table");
  // After an accept or while halted the winner's vector may stand with valid low
  a_idle_zero: assert property (!irq_valid && !$past(irq_valid && vector_ack && !core_halted)
    && !$past(core_halted) |-> irq_vector == 8'h00)
    else $error("vector shown with no winner");
  a_ack_drop: assert property (s_accept |=> !irq_valid)
    else $error("valid stayed after accept");
  a_high_block: assert property (in_service_high |-> !irq_valid)
    else $error("request shown during high service");
  a_top_wins: assert property (ext_req_zero && src_enable[0] && src_high_level[0]
    && !in_service_high && !core_halted && !vector_ack |=> irq_valid && irq_vector == 8'h03)
    else $error("top source not shown");
  a_edge_bits: assert property (edge_pending[5:0] == 6'h00)
    else $error("edge flag on a level source");
  a_stop_halts: assert property (stop_mode_enter && !core_halted |=> core_halted)
    else $error("stop not entered");
  a_wake_short: assert property (cnt <= WAKE_CLOCKS + 4)
    else $error("settle too long");
  a_wake_long: assert property ($fell(core_halted) |-> woke && cnt == WAKE_CLOCKS)
    else $error("settle too short");
endmodule : tlip_checker
bind tlip_prioritizer tlip_checker #(.WAKE_CLOCKS(WAKE_CLOCKS)) u_chk (.*);
`default_nettype wire

// file: test/tlip_core_model.sv
// Core-side model: takes presented vectors and returns from each service.
// Assumes the registered irq_valid/irq_vector handshake of the prioritizer.
`default_nettype none
module tlip_core_model #(
  parameter int RET = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // From the prioritizer and bench
  input wire logic irq_valid,
  input wire logic [7:0] irq_vector,
  input wire logic stall,
  // To the prioritizer and bench
  output logic vector_ack,
  output logic service_return,
  output logic [7:0] got_vec,
  output logic [7:0] n_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  int depth;
  int cnt;
  ////////////////////////////////////////
  // Ack follows valid a cycle later and drops after each accept; a slow core stalls it
  always_ff @(posedge clk) begin
    if (rst) begin
      vector_ack <= 1'b0;
      service_return <= 1'b0;
      depth <= 0;
      cnt <= 0;
      n_taken <= 8'h00;
    end else if (vector_ack && irq_valid) begin
      vector_ack <= 1'b0;
      service_return <= 1'b0;
      got_vec <= irq_vector;
      n_taken <= n_taken + 8'h01;
      depth <= depth + 1;
      cnt <= 0;
    end else begin
      vector_ack <= irq_valid && !stall;
      service_return <= (depth > 0 && cnt >= RET);
      if (depth > 0 && cnt >= RET) begin
        depth <= depth - 1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : tlip_core_model
`default_nettype wire

// file: test/two_level_interrupt_prioritizer_test.sv
// Self-checking bench for the prioritizer with a core model on its far side.
// Assumes a 4 ns clock and a short settle count.
`default_nettype none
module two_level_interrupt_prioritizer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAKE = 8;
  localparam logic [9:0] RQ [3] = '{10'h3FF, 10'h3F0, 10'h3FF};
  localparam logic [9:0] HI [3] = '{10'h000, 10'h000, 10'h200};
  localparam logic [7:0] EX [3] = '{8'h03, 8'h23, 8'h5B};
  // Edge flags left after the take: only a served edge source loses its flag
  localparam logic [9:0] EP [3] = '{10'h3C0, 10'h3C0, 10'h1C0};
  localparam logic [7:0] VT [10] = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B, 8'h43, 8'h4B, 8'h53, 8'h5B};
  logic clk, rst, rx, stop, stall, irq_valid, in_service_high, in_service_low, core_halted;
  logic vector_ack, service_return;
  logic [9:0] lv, en, hl, edge_pending;
  logic [7:0] irq_vector, got_vec, n_taken;
  int n_tests = 0;
  int n_mismatch = 0;
  ////////////////////////////////////////
  // Three and five are falling-edge sources, so a request drives them low
  tlip_prioritizer #(.WAKE_CLOCKS(WAKE)) uut (.clk, .rst, .clk_en(1'b1), .ext_req_zero(lv[0]),
    .timer_zero_overflow(lv[1]), .ext_req_one(lv[2]), .timer_one_overflow(lv[3]),
    .serial_tx_done_flag(lv[4]), .serial_rx_done_flag(rx), .timer_two_overflow(lv[5]),
    .ext_req_two(lv[6]), .ext_req_three(~lv[7]), .ext_req_four(lv[8]), .ext_req_five(~lv[9]),
    .src_enable(en), .src_high_level(hl), .stop_mode_enter(stop), .vector_ack, .service_return,
    .irq_valid, .irq_vector, .edge_pending, .in_service_high, .in_service_low, .core_halted);
  tlip_core_model core (.clk, .rst, .irq_valid, .irq_vector, .stall, .vector_ack, .service_return,
    .got_vec, .n_taken);
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task check(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : check
  // Reset between scenarios so stale edge flags never leak across
  task reset_dut;
    rst = 1'b1;
    lv = 10'h000;
    rx = 1'b0;
    stop = 1'b0;
    stall = 1'b0;
    step(2);
    rst = 1'b0;
  endtask : reset_dut
  task take(input logic [7:0] k, input logic [7:0] e, input string m);
    for (int c = 0; c < 100 && n_taken == k; c++) step(1);
    check(n_taken != k && got_vec === e, m);
  endtask : take
  task t_vectors;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 10; i++) begin
        reset_dut;
        en = 10'h001 << i;
        hl = j ? en : 10'h000;
        lv[i] = 1'b1;
        take(8'h00, VT[i], "vector");
        check(edge_pending === 10'h000, "edge flag left after take");
      end
    end
    reset_dut;
    en = 10'h010;
    rx = 1'b1;
    take(8'h00, 8'h23, "serial receive");
  endtask : t_vectors
  task t_order;
    for (int j = 0; j < 3; j++) begin
      reset_dut;
      en = 10'h3FF;
      hl = HI[j];
      stall = 1'b1;
      lv = RQ[j];
      step(3);
      check(edge_pending === 10'h3C0, "edge flags not set");
      stall = 1'b0;
      take(8'h00, EX[j], "order");
      check(edge_pending === EP[j], "edge flag clear");
    end
  endtask : t_order
  task t_preempt;
    reset_dut;
    en = 10'h3FF;
    hl = 10'h001;
    lv[1] = 1'b1;
    take(8'h00, 8'h0B, "low service");
    check(in_service_low, "low level");
    lv = 10'h005;
    take(8'h01, 8'h03, "preempt");
    check(in_service_high && in_service_low, "nesting");
  endtask : t_preempt
  task t_wake;
    int c;
    reset_dut;
    en = 10'h040;
    stop = 1'b1;
    step(1);
    stop = 1'b0;
    check(core_halted, "halt");
    step(3);
    lv[6] = 1'b1;
    for (c = 0; c < 100 && core_halted; c++) step(1);
    check(c == WAKE + 1, "settle");
  endtask : t_wake
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  // Watchdog, well above the under two hundred cycles the run needs
  initial begin
    #60000;
    n_mismatch++;
    end_of_test;
  end
  // Main sequence
  initial begin
    en = 10'h000;
    hl = 10'h000;
    reset_dut;
    t_vectors;
    t_order;
    t_preempt;
    t_wake;
    end_of_test;
  end
endmodule : two_level_interrupt_prioritizer_test
`default_nettype wire

// file: verilog/tlip_prioritizer.sv
// Two-level interrupt prioritizer: ten sources, high/low level, fixed vectors.
// Assumes a core that acknowledges each taken vector and signals return from service.
// Functional notes
// - Ten sources, two levels, fixed natural ranks one through ten.
// - Each source has its own software-set high or low level select.
// - Timer two and external inputs two to five rank below originals.
// - External zero vectors 03h rank 1; timer zero 0Bh rank 2.
// - External one vectors 13h rank 3; timer one 1Bh rank 4.
// - Serial request is transmit-done OR receive-done, vector 23h rank 5.
// - Timer two vectors 2Bh rank 6; external two 43h rank 7.
// - External three, four, five vector 4Bh, 53h, 5Bh, ranks 8-10.
// - External two to five edge detected, wake stop, resume after 65536 clocks.
`default_nettype none

module tlip_prioritizer #(
  parameter int unsigned WAKE_CLOCKS = tlip_pkg::WAKE_CLOCKS
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // Request sources, levels sampled each cycle
  input wire logic ext_req_zero,
  input wire logic timer_zero_overflow,
  input wire logic ext_req_one,
  input wire logic timer_one_overflow,
  input wire logic serial_tx_done_flag,
  input wire logic serial_rx_done_flag,
  input wire logic timer_two_overflow,
  input wire logic ext_req_two,
  input wire logic ext_req_three,
  input wire logic ext_req_four,
  input wire logic ext_req_five,
  // Software controls
  input wire logic [tlip_pkg::NUM_SRC-1:0] src_enable,
  input wire logic [tlip_pkg::NUM_SRC-1:0] src_high_level,
  input wire logic stop_mode_enter,
  // Core handshake
  input wire logic vector_ack,
  input wire logic service_return,
  output logic irq_valid,
  output logic [tlip_pkg::VEC_W-1:0] irq_vector,
  output logic [tlip_pkg::NUM_SRC-1:0] edge_pending,
  output logic in_service_high,
  output logic in_service_low,
  output logic core_halted
);

  ////////////////////////////////////////////////////////////////////////////
  // Request vector in natural-rank order

  logic [tlip_pkg::NUM_SRC-1:0] level_req;
  logic serial_port_request;
  logic [3:0] ext_hi_raw;
  logic [3:0] ext_prev;
  logic [3:0] next_ext_prev;
  logic [3:0] ext_edge;

  // Inputs two and four rise-detect, three and five fall-detect
  assign ext_hi_raw = {~ext_req_five, ext_req_four, ~ext_req_three, ext_req_two};
  assign ext_edge = ext_hi_raw & ~ext_prev;
  assign serial_port_request = serial_tx_done_flag | serial_rx_done_flag;

  // Original five first, additions after them
  always_comb begin
    level_req = '0;
    level_req[tlip_pkg::SRC_EXT0] = ext_req_zero;
    level_req[tlip_pkg::SRC_TMR0] = timer_zero_overflow;
    level_req[tlip_pkg::SRC_EXT1] = ext_req_one;
    level_req[tlip_pkg::SRC_TMR1] = timer_one_overflow;
    level_req[tlip_pkg::SRC_SER] = serial_port_request;
    level_req[tlip_pkg::SRC_TMR2] = timer_two_overflow;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge flags for the added external inputs

  logic [tlip_pkg::NUM_SRC-1:0] next_edge_pending;
  logic [tlip_pkg::NUM_SRC-1:0] ack_clear;

  // Set wins over the clear from an acknowledge in the same cycle
  always_comb begin
    next_ext_prev = ext_hi_raw;
    next_edge_pending = edge_pending & ~ack_clear;
    next_edge_pending[tlip_pkg::SRC_EXT5:tlip_pkg::SRC_EXT2] =
      next_edge_pending[tlip_pkg::SRC_EXT5:tlip_pkg::SRC_EXT2] | ext_edge;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev <= 4'h0;
      edge_pending <= tlip_pkg::PEND_RESET;
    end else if (clk_en) begin
      ext_prev <= next_ext_prev;
      edge_pending <= next_edge_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  logic [tlip_pkg::NUM_SRC-1:0] active;
  logic [tlip_pkg::NUM_SRC-1:0] hi_req;
  logic [tlip_pkg::NUM_SRC-1:0] lo_req;
  logic win_found;
  logic win_high;
  logic [3:0] win_idx;
  logic [tlip_pkg::VEC_W-1:0] win_vec;

  function automatic logic [tlip_pkg::VEC_W-1:0] vec_of(input logic [3:0] idx);
    logic [tlip_pkg::VEC_W-1:0] v;
    v = tlip_pkg::VEC_RESET;
    unique case (idx)
      4'h0: v = tlip_pkg::VEC_EXT0;
      4'h1: v = tlip_pkg::VEC_TMR0;
      4'h2: v = tlip_pkg::VEC_EXT1;
      4'h3: v = tlip_pkg::VEC_TMR1;
      4'h4: v = tlip_pkg::VEC_SER;
      4'h5: v = tlip_pkg::VEC_TMR2;
      4'h6: v = tlip_pkg::VEC_EXT2;
      4'h7: v = tlip_pkg::VEC_EXT3;
      4'h8: v = tlip_pkg::VEC_EXT4;
      4'h9: v = tlip_pkg::VEC_EXT5;
      default: v = tlip_pkg::VEC_RESET;
    endcase
    return v;
  endfunction : vec_of

  // Per-source level select splits requests into two pools
  assign active = (level_req | edge_pending) & src_enable;
  assign hi_req = active & src_high_level;
  assign lo_req = active & ~src_high_level;

  // Nothing at or below the level in service may win; lowest index wins in a pool
  always_comb begin
    win_found = 1'b0;
    win_high = 1'b0;
    win_idx = 4'h0;
    if (!in_service_high) begin
      for (int i = tlip_pkg::NUM_SRC - 1; i >= 0; i--) begin
        if (hi_req[i]) begin
          win_found = 1'b1;
          win_high = 1'b1;
          win_idx = 4'(i);
        end
      end
      if (!win_found && !in_service_low) begin
        for (int i = tlip_pkg::NUM_SRC - 1; i >= 0; i--) begin
          if (lo_req[i]) begin
            win_found = 1'b1;
            win_idx = 4'(i);
          end
        end
      end
    end
  end

  assign win_vec = vec_of(win_idx);

  ////////////////////////////////////////////////////////////////////////////
  // Service tracking and vector output

  logic next_irq_valid;
  logic [tlip_pkg::VEC_W-1:0] next_irq_vector;
  logic [3:0] irq_idx;
  logic [3:0] next_irq_idx;
  logic irq_high;
  logic next_irq_high;
  logic next_in_service_high;
  logic next_in_service_low;
  logic taken;

  assign taken = irq_valid && vector_ack && !core_halted;

  // Acknowledge clears the edge flag of the served source only
  always_comb begin
    ack_clear = '0;
    if (taken) begin
      ack_clear[irq_idx] = 1'b1;
    end
  end

  // Vector is registered; it re-evaluates every cycle so a preemptor replaces a waiter
  always_comb begin
    next_in_service_high = in_service_high;
    next_in_service_low = in_service_low;
    if (service_return) begin
      // Return closes the highest level in service first
      if (in_service_high) begin
        next_in_service_high = 1'b0;
      end else begin
        next_in_service_low = 1'b0;
      end
    end
    if (taken) begin
      if (irq_high) begin
        next_in_service_high = 1'b1;
      end else begin
        next_in_service_low = 1'b1;
      end
    end
    next_irq_valid = win_found && !taken && !core_halted;
    next_irq_vector = win_found ? win_vec : tlip_pkg::VEC_RESET;
    next_irq_idx = win_idx;
    next_irq_high = win_high;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_valid <= 1'b0;
      irq_vector <= tlip_pkg::VEC_RESET;
      irq_idx <= 4'h0;
      irq_high <= 1'b0;
      in_service_high <= 1'b0;
      in_service_low <= 1'b0;
    end else if (clk_en) begin
      irq_valid <= next_irq_valid;
      irq_vector <= next_irq_vector;
      irq_idx <= next_irq_idx;
      irq_high <= next_irq_high;
      in_service_high <= next_in_service_high;
      in_service_low <= next_in_service_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop mode and oscillator settling

  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_SETTLE} tlip_pwr_type;

  localparam logic [tlip_pkg::WAKE_CNT_W-1:0] WAKE_LAST = tlip_pkg::WAKE_CNT_W'(WAKE_CLOCKS - 1);

  tlip_pwr_type pwr_state;
  tlip_pwr_type next_pwr_state;
  logic [tlip_pkg::WAKE_CNT_W-1:0] wake_cnt;
  logic [tlip_pkg::WAKE_CNT_W-1:0] next_wake_cnt;

  // Only the edge-detected inputs can wake; internal sources need a clock that is off
  always_comb begin
    next_pwr_state = pwr_state;
    next_wake_cnt = wake_cnt;
    unique case (pwr_state)
      ST_RUN: begin
        if (stop_mode_enter) begin
          next_pwr_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (|(ext_edge & src_enable[tlip_pkg::SRC_EXT5:tlip_pkg::SRC_EXT2])) begin
          next_pwr_state = ST_SETTLE;
          next_wake_cnt = '0;
        end
      end
      ST_SETTLE: begin
        if (wake_cnt == WAKE_LAST) begin
          next_pwr_state = ST_RUN;
        end else begin
          next_wake_cnt = wake_cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwr_state <= ST_RUN;
      wake_cnt <= '0;
    end else if (clk_en) begin
      pwr_state <= next_pwr_state;
      wake_cnt <= next_wake_cnt;
    end
  end

  assign core_halted = (pwr_state != ST_RUN);

endmodule : tlip_prioritizer

`default_nettype wire
